// file: bench/stfr_asserts.sv
// checker on the ports of the responder
// assumes a bind from the testbench top file
`timescale 1ns/1ns
`default_nettype none

module stfr_asserts (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic       clear_faults,
  input wire logic       fault_bit_clear,
  input wire logic       enable_cmd,
  input wire logic       other_fault_off,
  input wire logic       output_on,
  input wire logic       startup_fault,
  input wire logic       fault_latched,
  input wire logic [2:0] attempt_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ======
  // properties
  property p_cfg_rd;
    cmd_wr && cmd_code == 8'h63 ##1 cmd_code == 8'h63 && !cmd_wr |=> cmd_rdata == $past(cmd_wdata, 2);
  endproperty
  property p_unmapped;
    cmd_code != 8'h63 |=> cmd_rdata == 8'h00;
  endproperty
  property p_en_off;
    !enable_cmd |=> !output_on;
  endproperty
  property p_oth_off;
    other_fault_off |=> !output_on;
  endproperty
  property p_latch_off;
    fault_latched |-> !output_on;
  endproperty
  property p_latch_hold;
    fault_latched && enable_cmd && !clear_faults && !fault_bit_clear |=> fault_latched;
  endproperty
  property p_clr;
    fault_latched && clear_faults |=> !fault_latched;
  endproperty
  property p_att_step;
    attempt_count != $past(attempt_count) && attempt_count != 3'h0 |-> attempt_count == $past(attempt_count) + 3'h1;
  endproperty
  property p_rise;
    $rose(output_on) |-> $past(enable_cmd) && !$past(other_fault_off);
  endproperty

  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_en_off: assert property (p_en_off) else $error("output on while disabled");
  a_oth_off: assert property (p_oth_off) else $error("output on during other fault");
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
  a_latch_hold: assert property (p_latch_hold) else $error("latch left without clear");
  a_clr: assert property (p_clr) else $error("clear did not release latch");
  a_att_step: assert property (p_att_step) else $error("attempt count jumped");
  a_rise: assert property (p_rise) else $error("output rose without enable");

  c_fault: cover property ($rose(startup_fault));
  c_latch: cover property ($rose(fault_latched));
  c_six: cover property (attempt_count == 3'h6);
endmodule // stfr_asserts

`default_nettype wire

// file: bench/stfr_plant.sv
// far side model: converter output stage and its uv comparator
// assumes output_on from the responder, same clock
`timescale 1ns/1ns
`default_nettype none

module stfr_plant (
  input  wire logic mclk,
  input  wire logic output_on,
  input  wire logic healthy,
  output logic      vout_above_uv
);
  logic [3:0] rise_cnt;

  // ======
  // output rises 8 cycles after enable if healthy, drops when off
  always_ff @(posedge mclk) begin
    if (!output_on) rise_cnt <= 4'h0;
    else if (rise_cnt != 4'hf) rise_cnt <= rise_cnt + 4'h1;
  end
  assign vout_above_uv = healthy && output_on && (rise_cnt >= 4'h8);
endmodule // stfr_plant

`default_nettype wire

// file: bench/tb.sv
// self-checking testbench of the start-up timeout fault responder
// assumes stfr_plant and stfr_asserts compiled before it
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        mclk            = 1'b0;
  logic        rst_n           = 1'b0;
  logic [7:0]  cmd_code        = 8'h00;
  logic        cmd_wr          = 1'b0;
  logic [7:0]  cmd_wdata       = 8'h00;
  logic [7:0]  cmd_rdata;
  logic        clear_faults    = 1'b0;
  logic        fault_bit_clear = 1'b0;
  logic        enable_cmd      = 1'b0;
  logic        other_fault_off = 1'b0;
  logic        healthy         = 1'b1;
  logic        vout_above_uv;
  logic [15:0] limit           = 16'h0002;
  logic [23:0] unit            = 24'h000004;
  logic        output_on;
  logic        startup_fault;
  logic        fault_latched;
  logic [2:0]  attempt_count;
  int          err_total       = 0;
  int          cmp_count       = 0;
  int          cyc             = 0;
  int          t0;
  int          un[3]           = '{4, 4, 8};
  int          cd[3]           = '{3, 5, 3};

  always #5 mclk = ~mclk;

  startup_timeout_fault_responder #(.MS_CYCLES(10)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .clear_faults(clear_faults), .fault_bit_clear(fault_bit_clear),
    .enable_cmd(enable_cmd), .other_fault_off(other_fault_off), .vout_above_uv(vout_above_uv),
    .startup_timeout_limit(limit), .vout_time_unit_cycles(unit), .output_on(output_on),
    .startup_fault(startup_fault), .fault_latched(fault_latched), .attempt_count(attempt_count)
  );
  stfr_plant plant_u (.mclk(mclk), .output_on(output_on), .healthy(healthy), .vout_above_uv(vout_above_uv));

  // ======
  // tasks
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge mclk);
    cmd_code  <= code;
    cmd_wdata <= data;
    cmd_wr    <= 1'b1;
    @(posedge mclk);
    cmd_wr    <= 1'b0;
  endtask

  task rd(input logic [7:0] code, input logic [7:0] exp);
    @(posedge mclk);
    cmd_code <= code;
    repeat (2) @(posedge mclk);
    #1;
    chk("rdata", 16'(exp), 16'(cmd_rdata));
  endtask

  task start(input logic [7:0] cfg, input logic ok);
    @(posedge mclk);
    enable_cmd   <= 1'b0;
    clear_faults <= 1'b1;
    healthy      <= ok;
    @(posedge mclk);
    clear_faults <= 1'b0;
    wr(8'h63, cfg);
    enable_cmd   <= 1'b1;
  endtask

  task wo(input logic v);
    while (output_on !== v) @(negedge mclk);
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  // ======
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h63, 8'hc0);
    wr(8'h64, 8'h11);
    rd(8'h64, 8'h00);
    wr(8'h63, 8'h5a);
    rd(8'h63, 8'h5a);
    start(8'h00, 1'b1);
    repeat (60) @(negedge mclk);
    chk("good_fault", 16'h0, 16'(startup_fault));
    start(8'h00, 1'b0);
    while (startup_fault !== 1'b1) @(negedge mclk);
    repeat (50) @(negedge mclk);
    chk("ignore_on", 16'h1, 16'(output_on));
    start(8'hc3, 1'b0);
    while (startup_fault !== 1'b1) @(negedge mclk);
    repeat (100) @(negedge mclk);
    chk("latch_on", 16'h0, 16'(output_on));
    chk("latched", 16'h1, 16'(fault_latched));
    @(posedge mclk);
    fault_bit_clear <= 1'b1;
    @(posedge mclk);
    fault_bit_clear <= 1'b0;
    @(negedge mclk);
    chk("unlatched", 16'h0, 16'(fault_latched));
    for (int r = 0; r < 7; r++) begin
      start({2'b10, 3'(r), 3'h0}, 1'b0);
      while (fault_latched !== 1'b1) @(negedge mclk);
      chk("attempts", 16'(r), 16'(attempt_count));
      chk("retry_off", 16'h0, 16'(output_on));
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      unit <= 24'(un[i]);
      start({2'b10, 3'h1, 3'(cd[i])}, 1'b0);
      wo(1'b1);
      t0 = cyc;
      wo(1'b0);
      wo(1'b1);
      chk("spacing", 16'(un[i] << cd[i]), 16'(cyc - t0));
    end
    start(8'h4b, 1'b0);
    while (startup_fault !== 1'b1) @(negedge mclk);
    repeat (50) @(negedge mclk);
    chk("run_on", 16'h1, 16'(output_on));
    while (fault_latched !== 1'b1) @(negedge mclk);
    chk("run_retry", 16'h1, 16'(attempt_count));
    start(8'hb8, 1'b0);
    repeat (300) @(negedge mclk);
    chk("forever", 16'h0, 16'(fault_latched));
    @(posedge mclk);
    other_fault_off <= 1'b1;
    repeat (3) @(negedge mclk);
    chk("forced_off", 16'h0, 16'(output_on));
    @(posedge mclk);
    other_fault_off <= 1'b0;
    limit <= 16'h0000;
    start(8'hc0, 1'b0);
    repeat (100) @(negedge mclk);
    chk("no_limit", 16'h1, 16'(output_on));
    end_of_test();
  end
endmodule // tb

bind startup_timeout_fault_responder stfr_asserts asserts_u (
  .mclk(mclk), .rst_n(rst_n), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
  .cmd_rdata(cmd_rdata), .clear_faults(clear_faults), .fault_bit_clear(fault_bit_clear),
  .enable_cmd(enable_cmd), .other_fault_off(other_fault_off), .output_on(output_on),
  .startup_fault(startup_fault), .fault_latched(fault_latched), .attempt_count(attempt_count)
);

`default_nettype wire

// file: hdl/startup_timeout_fault_responder.sv
// start-up timeout detection and fault response sequencer
// assumes a same-clock command engine, an asynchronous vout comparator
`timescale 1ns/1ns
`default_nettype none
`include "stfr_defines.svh"

module startup_timeout_fault_responder
  import stfr_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `STFR_MS_CYCLES
)(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_wr,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  cmd_rdata,
  input  wire logic        clear_faults,
  input  wire logic        fault_bit_clear,
  input  wire logic        enable_cmd,
  input  wire logic        other_fault_off,
  input  wire logic        vout_above_uv,
  input  wire logic [15:0] startup_timeout_limit,
  input  wire logic [23:0] vout_time_unit_cycles,
  output logic             output_on,
  output logic             startup_fault,
  output logic             fault_latched,
  output logic      [2:0]  attempt_count
);

  // ========================================================
  // parameter check
  generate
    if (MS_CYCLES < 1) begin : g_bad_ms
      $error("MS_CYCLES must be at least one");
    end
  endgenerate

  // ========================================================
  // helpers
  function automatic logic [31:0] delay_cycles(
    input logic [23:0] unit,
    input logic [2:0]  code
  );
    delay_cycles = {8'h0, unit} << code;
  endfunction

  function automatic logic retries_left(
    input logic [2:0] setting,
    input logic [2:0] used
  );
    if (setting == `STFR_RETRY_NONE) begin
      retries_left = 1'b0;
    end else if (setting == `STFR_RETRY_FOREVER) begin
      retries_left = 1'b1;
    end else begin
      retries_left = (used < setting);
    end
  endfunction

  function automatic seq_state_t after_fail(
    input logic [2:0] setting,
    input logic [2:0] used
  );
    if (retries_left(setting, used)) begin
      after_fail = ST_WAIT;
    end else begin
      after_fail = ST_LATCH;
    end
  endfunction

  // start pulse and expiry flag each take one clock of the interval
  function automatic logic [31:0] timer_load(
    input logic [31:0] len
  );
    if (len > 32'h2) begin
      timer_load = len - 32'h2;
    end else begin
      timer_load = 32'h1;
    end
  endfunction

  // ========================================================
  // state and timer link
  resp_reg_t     s_reg;
  resp_reg_t     s_next;
  stfr_timer_if  tmr ();

  stfr_delay_timer u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .t     (tmr.timer)
  );

  assign tmr.start = s_reg.tmr_start;
  assign tmr.load  = timer_load(s_reg.tmr_load);

  // ========================================================
  // decoded fields
  resp_mode_t  mode;
  logic [2:0]  retry_set;
  logic [2:0]  delay_code;
  logic [31:0] delay_len;
  logic        tmr_done;
  logic        timed_out;
  logic        do_clear;

  always_comb begin
    mode       = resp_mode_t'(s_reg.cfg[`STFR_RESP_MSB:`STFR_RESP_LSB]);
    retry_set  = s_reg.cfg[`STFR_RETRY_MSB:`STFR_RETRY_LSB];
    delay_code = s_reg.cfg[`STFR_DELAY_MSB:`STFR_DELAY_LSB];
    delay_len  = delay_cycles(vout_time_unit_cycles, delay_code);
    tmr_done   = tmr.expired && !s_reg.tmr_start;
    timed_out  = (startup_timeout_limit != 16'h0) &&
                 (s_reg.ms_cnt >= startup_timeout_limit);
    do_clear   = clear_faults || fault_bit_clear;
  end

  // ========================================================
  // next state
  always_comb begin
    s_next           = s_reg;
    s_next.tmr_start = 1'b0;
    s_next.vsync1    = vout_above_uv;
    s_next.vsync2    = s_reg.vsync1;

    // configuration byte write and read-back
    if (cmd_wr && (cmd_code == `STFR_CMD_CFG)) begin
      s_next.cfg = cmd_wdata;
    end
    if (cmd_code == `STFR_CMD_CFG) begin
      s_next.rdata = s_reg.cfg;
    end else begin
      s_next.rdata = 8'h0;
    end

    // sticky fault flag cleared by software
    if (do_clear) begin
      s_next.fault = 1'b0;
    end

    unique case (s_reg.state)
      ST_OFF: begin
        s_next.out_on = 1'b0;
        if (enable_cmd && !other_fault_off) begin
          s_next.state     = ST_START;
          s_next.out_on    = 1'b1;
          s_next.attempts  = 3'h0;
          s_next.ms_sub    = 32'h0;
          s_next.ms_cnt    = 16'h0;
          s_next.tmr_start = 1'b1;
          s_next.tmr_load  = delay_len;
        end
      end

      ST_START: begin
        if (s_reg.ms_sub >= MS_CYCLES - 1) begin
          s_next.ms_sub = 32'h0;
          if (s_reg.ms_cnt != 16'hffff) begin
            s_next.ms_cnt = s_reg.ms_cnt + 16'h1;
          end
        end else begin
          s_next.ms_sub = s_reg.ms_sub + 32'h1;
        end
        if (s_reg.vsync2) begin
          s_next.state = ST_RUN;
        end else if (timed_out) begin
          s_next.fault = 1'b1;
          unique case (mode)
            RESP_IGNORE: begin
              s_next.state = ST_RUN;
            end
            RESP_RUN_RETRY: begin
              s_next.state     = ST_HOLD;
              s_next.tmr_start = 1'b1;
              s_next.tmr_load  = delay_len;
            end
            RESP_DIS_RETRY: begin
              s_next.out_on  = 1'b0;
              s_next.state   = after_fail(retry_set, s_reg.attempts);
              s_next.latched = (s_next.state == ST_LATCH);
            end
            RESP_LATCH_OFF: begin
              s_next.out_on  = 1'b0;
              s_next.state   = ST_LATCH;
              s_next.latched = 1'b1;
            end
          endcase
        end
      end

      ST_RUN: begin
        s_next.out_on = 1'b1;
      end

      ST_HOLD: begin
        if (s_reg.vsync2) begin
          s_next.state = ST_RUN;
        end else if (tmr_done) begin
          s_next.out_on  = 1'b0;
          s_next.state   = after_fail(retry_set, s_reg.attempts);
          s_next.latched = (s_next.state == ST_LATCH);
        end
      end

      ST_WAIT: begin
        s_next.out_on = 1'b0;
        if (tmr_done) begin
          s_next.state     = ST_START;
          s_next.out_on    = 1'b1;
          s_next.ms_sub    = 32'h0;
          s_next.ms_cnt    = 16'h0;
          s_next.tmr_start = 1'b1;
          s_next.tmr_load  = delay_len;
          if (retry_set != `STFR_RETRY_FOREVER) begin
            s_next.attempts = s_reg.attempts + 3'h1;
          end
        end
      end

      ST_LATCH: begin
        s_next.out_on = 1'b0;
      end

      default: begin
        s_next.state  = ST_OFF;
        s_next.out_on = 1'b0;
      end
    endcase

    // clearing a latched or retrying sequence starts afresh
    if (do_clear && ((s_reg.state == ST_LATCH) || (s_reg.state == ST_WAIT))) begin
      s_next.state    = ST_OFF;
      s_next.out_on   = 1'b0;
      s_next.latched  = 1'b0;
      s_next.attempts = 3'h0;
    end

    // off command or another fault ends the sequence, but the sticky fault flag is kept
    if (!enable_cmd || other_fault_off) begin
      s_next.state     = ST_OFF;
      s_next.out_on    = 1'b0;
      s_next.latched   = 1'b0;
      s_next.attempts  = 3'h0;
      s_next.ms_sub    = 32'h0;
      s_next.ms_cnt    = 16'h0;
      s_next.tmr_start = 1'b0;
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{
        state:     ST_OFF,
        cfg:       `STFR_CFG_RESET,
        rdata:     8'h0,
        vsync1:    1'b0,
        vsync2:    1'b0,
        out_on:    1'b0,
        fault:     1'b0,
        latched:   1'b0,
        attempts:  3'h0,
        ms_sub:    32'h0,
        ms_cnt:    16'h0,
        tmr_start: 1'b0,
        tmr_load:  32'h0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ========================================================
  // outputs
  assign cmd_rdata     = s_reg.rdata;
  assign output_on     = s_reg.out_on;
  assign startup_fault = s_reg.fault;
  assign fault_latched = s_reg.latched;
  assign attempt_count = s_reg.attempts;

endmodule // startup_timeout_fault_responder

`default_nettype wire

// file: hdl/stfr_defines.svh
// constants of the start-up timeout fault responder
// assumes inclusion by bare name from package and modules
`ifndef STFR_DEFINES_SVH
`define STFR_DEFINES_SVH

// ==========================================================
// command codes and configuration byte layout
`define STFR_CMD_CFG        8'h63
`define STFR_CMD_LIMIT      8'h62
`define STFR_CMD_TUNIT      8'hd2
`define STFR_CFG_RESET      8'hc0
`define STFR_RESP_MSB       7
`define STFR_RESP_LSB       6
`define STFR_RETRY_MSB      5
`define STFR_RETRY_LSB      3
`define STFR_DELAY_MSB      2
`define STFR_DELAY_LSB      0
`define STFR_RETRY_NONE     3'h0
`define STFR_RETRY_FOREVER  3'h7

// ==========================================================
// timing
`define STFR_CLK_PERIOD_NS  10
`define STFR_MS_NS          1000000
`define STFR_MS_CYCLES      ((`STFR_MS_NS + `STFR_CLK_PERIOD_NS - 1) / `STFR_CLK_PERIOD_NS)

`endif

// file: hdl/stfr_delay_timer.sv
// one-shot delay timer counting mclk cycles
// assumes start is a one-cycle pulse from the responder
`timescale 1ns/1ns
`default_nettype none

module stfr_delay_timer
  import stfr_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  stfr_timer_if.timer t
);

  tmr_reg_t s_reg;
  tmr_reg_t s_next;

  // ========================================================
  // count down, expired stays high until next start
  always_comb begin
    s_next = s_reg;
    if (t.start) begin
      s_next.cnt     = (t.load == 32'h0) ? 32'h1 : t.load;
      s_next.expired = 1'b0;
    end else if (s_reg.cnt == 32'h1) begin
      s_next.cnt     = 32'h0;
      s_next.expired = 1'b1;
    end else if (s_reg.cnt != 32'h0) begin
      s_next.cnt = s_reg.cnt - 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{cnt: 32'h0, expired: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign t.expired = s_reg.expired;

endmodule // stfr_delay_timer

`default_nettype wire

// file: hdl/stfr_pkg.sv
// types of the start-up timeout fault responder
// assumes stfr_defines.svh is on the include path
`include "stfr_defines.svh"

package stfr_pkg;

  // ========================================================
  // response codes
  typedef enum logic [1:0] {
    RESP_IGNORE    = 2'h0,
    RESP_RUN_RETRY = 2'h1,
    RESP_DIS_RETRY = 2'h2,
    RESP_LATCH_OFF = 2'h3
  } resp_mode_t;

  // ========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_OFF   = 6'h01,
    ST_START = 6'h02,
    ST_RUN   = 6'h04,
    ST_HOLD  = 6'h08,
    ST_WAIT  = 6'h10,
    ST_LATCH = 6'h20
  } seq_state_t;

  // ========================================================
  // whole state of the responder
  typedef struct packed {
    seq_state_t  state;
    logic [7:0]  cfg;
    logic [7:0]  rdata;
    logic        vsync1;
    logic        vsync2;
    logic        out_on;
    logic        fault;
    logic        latched;
    logic [2:0]  attempts;
    logic [31:0] ms_sub;
    logic [15:0] ms_cnt;
    logic        tmr_start;
    logic [31:0] tmr_load;
  } resp_reg_t;

  // whole state of the delay timer
  typedef struct packed {
    logic [31:0] cnt;
    logic        expired;
  } tmr_reg_t;

endpackage

// file: hdl/stfr_timer_if.sv
// link between the responder and its delay timer
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none

interface stfr_timer_if;
  logic        start;
  logic [31:0] load;
  logic        expired;

  modport ctrl (output start, output load, input expired);
  modport timer (input start, input load, output expired);
endinterface : stfr_timer_if

`default_nettype wire
